//--- design/ccp_pkg.sv
// Constants for the cache partition configuration bank
package ccp_pkg;
	// Byte offsets within a feature page
	localparam logic [12:0] CMAX_OFFSET = 13'h0108;
	localparam logic [12:0] BITMAP_BASE = 13'h1000;
	localparam logic [9:0] BITMAP_LAST_WORD = 10'h3FF;
	// Implemented feature flags of the main feature id
	localparam logic HAS_CAPACITY_PARTITIONING = 1'h1;
	localparam logic HAS_PORTION_PARTITIONING = 1'h1;
	localparam logic HAS_INSTANCE_SELECT = 1'h1;
	localparam logic HAS_NARROWING = 1'h1;
	// Capacity and portion feature ids
	localparam logic [4:0] CAPACITY_FRACTION_WIDTH = 5'h0C;
	localparam logic [15:0] PORTION_BITMAP_WIDTH = 16'h0028;
	localparam logic [15:0] INTERNAL_PARTITION_MAX = 16'h0003;
	localparam logic [15:0] PARTITION_ID_MAX = 16'h0003;
	localparam logic [3:0] INSTANCE_MAX = 4'h1;
	// Storage shape: page, instance and partition form the entry index
	localparam int PART_BITS = 2;
	localparam int RIS_BITS = 1;
	localparam int WORD_BITS = 1;
	localparam int ENTRY_BITS = 1 + RIS_BITS + PART_BITS;
	localparam int ENTRIES = 16;
	localparam int WORDS = 2;
	// Implemented capacity bits sit at the top of the field
	localparam logic [15:0] CMAX_MASK = 16'hFFFF << (5'h10 - CAPACITY_FRACTION_WIDTH);
	localparam logic [15:0] CMAX_RESET = CMAX_MASK;
	localparam logic [31:0] BITMAP_RESET = 32'hFFFFFFFF;
endpackage

//--- design/ccp_config_regs.sv
// Cache capacity limit and portion bitmap configuration bank
`timescale 1ns/100ps
module ccp_config_regs
	import ccp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic bus_req,
	input wire logic bus_write,
	input wire logic bus_secure,
	input wire logic [12:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	output logic bus_ack_q,
	output logic [31:0] bus_rdata_q,
	input wire logic [15:0] sel_s_partition,
	input wire logic [3:0] sel_s_instance,
	input wire logic sel_s_internal,
	input wire logic [15:0] sel_ns_partition,
	input wire logic [3:0] sel_ns_instance,
	input wire logic sel_ns_internal,
	input wire logic qry_valid,
	input wire logic qry_secure,
	input wire logic [15:0] qry_partition,
	input wire logic [3:0] qry_instance,
	input wire logic [15:0] qry_portion,
	output logic qry_done_q,
	output logic qry_allow_q,
	output logic [15:0] qry_limit_q
);
	import ccp_pkg::*;

	// Per-entry storage, one entry per page, instance and partition
	// A flat array lets one index pick page, instance and partition;
	// a larger build only grows the package constants
	logic [15:0] cmax_q [ENTRIES];
	logic [31:0] bitmap_q [ENTRIES][WORDS];

	// Reserved mask for one bitmap word given its index
	// A word lies wholly below, on, or above the width boundary
	function automatic logic [31:0] word_mask(input logic [9:0] n);
		logic [31:0] m;
		m = 32'h00000000;
		if (n < PORTION_BITMAP_WIDTH[14:5])
		begin
			m = 32'hFFFFFFFF;
		end
		else if (n == PORTION_BITMAP_WIDTH[14:5])
		begin
			m = ~(32'hFFFFFFFF << PORTION_BITMAP_WIDTH[4:0]);
		end
		return m;
	endfunction

	// Selector of the page being accessed; each page has its own
	// Only the low id bits index storage; the range is checked below
	wire logic [15:0] acc_part;
	wire logic [3:0] acc_inst;
	wire logic acc_internal;
	assign acc_part = bus_secure ? sel_s_partition : sel_ns_partition;
	assign acc_inst = bus_secure ? sel_s_instance : sel_ns_instance;
	assign acc_internal = bus_secure ? sel_s_internal : sel_ns_internal;

	// Instance field is ignored when selection is absent
	wire logic [3:0] acc_inst_eff;
	assign acc_inst_eff = HAS_INSTANCE_SELECT ? acc_inst : 4'h0;

	// Highest id that indexes settings depends on narrowing
	// Both maxima are equal in this build, so either choice agrees
	wire logic [15:0] part_max;
	assign part_max = HAS_NARROWING ? INTERNAL_PARTITION_MAX : PARTITION_ID_MAX;

	// Internal flag must say narrowed ids when narrowing is present
	wire logic flag_ok;
	assign flag_ok = (acc_internal == HAS_NARROWING);

	// Ids above the maximum have no storage behind them
	wire logic part_ok;
	assign part_ok = (acc_part <= part_max);

	// Only the implemented cache instances carry settings
	wire logic inst_ok;
	assign inst_ok = (acc_inst_eff <= INSTANCE_MAX);

	// A mismatched flag or an id outside storage reads zero and drops
	// writes; the error report lives with the selector, not here
	wire logic sel_ok;
	assign sel_ok = flag_ok && part_ok && inst_ok;

	// Entry index fields: page, then instance, then partition
	wire logic [RIS_BITS-1:0] acc_inst_bits;
	wire logic [PART_BITS-1:0] acc_part_bits;
	wire logic [ENTRY_BITS-1:0] acc_entry;
	assign acc_inst_bits = acc_inst_eff[RIS_BITS-1:0];
	assign acc_part_bits = acc_part[PART_BITS-1:0];
	assign acc_entry = {bus_secure, acc_inst_bits, acc_part_bits};

	// Raw offset matches, identical in both pages
	wire logic at_cmax;
	wire logic in_bitmap_window;
	wire logic word_aligned;
	assign at_cmax = (bus_addr == CMAX_OFFSET);
	assign in_bitmap_window = (bus_addr[12] == BITMAP_BASE[12]);
	assign word_aligned = (bus_addr[1:0] == 2'h0);

	// An absent feature leaves its offsets reserved, reading zero
	wire logic hit_cmax;
	wire logic hit_bitmap;
	wire logic [9:0] word_idx;
	assign hit_cmax = at_cmax && HAS_CAPACITY_PARTITIONING;
	assign hit_bitmap = in_bitmap_window && word_aligned && HAS_PORTION_PARTITIONING;
	assign word_idx = bus_addr[11:2];

	// Words beyond storage are wholly reserved by the width
	wire logic word_in_store;
	wire logic [31:0] acc_word_mask;
	wire logic word_in_array;
	wire logic word_below_last;
	assign word_in_array = (word_idx < 10'(WORDS));
	assign word_below_last = (word_idx <= BITMAP_LAST_WORD);
	assign word_in_store = word_in_array && word_below_last;
	assign acc_word_mask = word_in_store ? word_mask(word_idx) : 32'h00000000;

	// Only the low index bits address the stored words
	wire logic [WORD_BITS-1:0] acc_word;
	assign acc_word = word_idx[WORD_BITS-1:0];

	// Write strobes; a refused selector still gets its answer
	// but changes nothing
	wire logic bitmap_live;
	wire logic do_write;
	wire logic wr_cmax;
	wire logic wr_bitmap;
	assign bitmap_live = hit_bitmap && word_in_store;
	assign do_write = bus_req && bus_write && sel_ok;
	assign wr_cmax = do_write && hit_cmax;
	assign wr_bitmap = do_write && bitmap_live;

	// Next stored values; reserved and unimplemented bits never reach storage
	wire logic [15:0] cmax_d;
	wire logic [31:0] bitmap_word_d;
	assign cmax_d = bus_wdata[15:0] & CMAX_MASK;
	assign bitmap_word_d = bus_wdata & acc_word_mask;

	// Read data; unmapped and reserved locations return zero
	wire logic [31:0] rd_cmax;
	wire logic [31:0] rd_bitmap;
	wire logic [31:0] rd_data;
	assign rd_cmax = {16'h0000, cmax_q[acc_entry] & CMAX_MASK};
	assign rd_bitmap = bitmap_q[acc_entry][acc_word] & acc_word_mask;
	assign rd_data = !sel_ok ? 32'h00000000 :
		hit_cmax ? rd_cmax :
		bitmap_live ? rd_bitmap :
		32'h00000000;

	// Capacity limit storage; unimplemented low bits are never kept
	// Every entry is reset, so no partition starts out limited
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			for (int e = 0; e < ENTRIES; e++)
			begin
				cmax_q[e] <= CMAX_RESET;
			end
		end
		else if (wr_cmax)
		begin
			cmax_q[acc_entry] <= cmax_d;
		end
	end

	// Portion bitmap storage; reserved bits are masked on write
	// Implemented bits reset to one so every portion starts permitted
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			for (int e = 0; e < ENTRIES; e++)
			begin
				for (int w = 0; w < WORDS; w++)
				begin
					bitmap_q[e][w] <= BITMAP_RESET & word_mask(10'(w));
				end
			end
		end
		else if (wr_bitmap)
		begin
			bitmap_q[acc_entry][acc_word] <= bitmap_word_d;
		end
	end

	// Next answer; a write or an idle cycle returns zero data
	wire logic bus_ack_d;
	wire logic rd_req;
	wire logic [31:0] bus_rdata_d;
	assign bus_ack_d = bus_req;
	assign rd_req = bus_req && !bus_write;
	assign bus_rdata_d = rd_req ? rd_data : 32'h00000000;

	// Every request is answered in the next cycle
	// There are no wait states, so the bus never stalls here
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			bus_ack_q <= 1'b0;
			bus_rdata_q <= 32'h00000000;
		end
		else
		begin
			bus_ack_q <= bus_ack_d;
			bus_rdata_q <= bus_rdata_d;
		end
	end

	// Allocation query from the cache side, same indexing as the bus
	wire logic [3:0] q_inst_eff;
	wire logic q_part_ok;
	wire logic q_inst_ok;
	wire logic q_ok;
	assign q_inst_eff = HAS_INSTANCE_SELECT ? qry_instance : 4'h0;
	assign q_part_ok = (qry_partition <= part_max);
	assign q_inst_ok = (q_inst_eff <= INSTANCE_MAX);
	assign q_ok = q_part_ok && q_inst_ok;

	// Query entry index, built like the bus entry
	wire logic [RIS_BITS-1:0] q_inst_bits;
	wire logic [PART_BITS-1:0] q_part_bits;
	wire logic [ENTRY_BITS-1:0] q_entry;
	assign q_inst_bits = q_inst_eff[RIS_BITS-1:0];
	assign q_part_bits = qry_partition[PART_BITS-1:0];
	assign q_entry = {qry_secure, q_inst_bits, q_part_bits};

	// Portion p selects word p[15:5] and bit p[4:0]
	wire logic [10:0] q_word_idx;
	wire logic [4:0] q_bit_idx;
	wire logic q_in_width;
	assign q_word_idx = qry_portion[15:5];
	assign q_bit_idx = qry_portion[4:0];
	// Portions past the width or past storage are never permitted
	wire logic q_below_width;
	wire logic q_word_in_store;
	assign q_below_width = (qry_portion < PORTION_BITMAP_WIDTH);
	assign q_word_in_store = (q_word_idx < 11'(WORDS));
	assign q_in_width = q_below_width && q_word_in_store;

	// A cleared bit, or a portion beyond the width, forbids allocation
	wire logic q_bit;
	assign q_bit = bitmap_q[q_entry][q_word_idx[WORD_BITS-1:0]][q_bit_idx];

	wire logic q_portion_ok;
	wire logic q_allow;
	assign q_portion_ok = q_ok && q_in_width && q_bit;
	assign q_allow = !HAS_PORTION_PARTITIONING || q_portion_ok;

	// Limit as fraction v/65536; without the feature nothing is limited
	wire logic [15:0] q_limit_stored;
	wire logic [15:0] q_cap_limit;
	wire logic [15:0] q_limit;
	assign q_limit_stored = cmax_q[q_entry] & CMAX_MASK;
	assign q_cap_limit = q_ok ? q_limit_stored : 16'h0000;
	assign q_limit = !HAS_CAPACITY_PARTITIONING ? 16'hFFFF : q_cap_limit;

	// Next query results; allow and limit hold between queries
	wire logic qry_done_d;
	wire logic qry_allow_d;
	wire logic [15:0] qry_limit_d;
	assign qry_done_d = qry_valid;
	assign qry_allow_d = qry_valid ? q_allow : qry_allow_q;
	assign qry_limit_d = qry_valid ? q_limit : qry_limit_q;

	// Query results are registered for the allocation pipeline
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			qry_done_q <= 1'b0;
			qry_allow_q <= 1'b0;
			qry_limit_q <= 16'h0000;
		end
		else
		begin
			qry_done_q <= qry_done_d;
			qry_allow_q <= qry_allow_d;
			qry_limit_q <= qry_limit_d;
		end
	end
endmodule

//--- verification/ccp_config_regs_assertions.sv
// Port checks for the cache partition configuration bank
`timescale 1ns/100ps
module ccp_config_regs_checker
	import ccp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic bus_req,
	input wire logic bus_write,
	input wire logic [12:0] bus_addr,
	input wire logic bus_ack_q,
	input wire logic [31:0] bus_rdata_q,
	input wire logic qry_valid,
	input wire logic [15:0] qry_partition,
	input wire logic [15:0] qry_portion,
	input wire logic qry_done_q,
	input wire logic qry_allow_q,
	input wire logic [15:0] qry_limit_q
);
	// One clock domain, so the checks share clock and reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A read request being taken
	sequence s_rd;
		bus_req && !bus_write;
	endsequence
	a_ack_one_later: assert property (bus_req |=> bus_ack_q)
		else $error("access not answered one cycle later");
	a_no_stray_ack: assert property (!bus_req |=> !bus_ack_q)
		else $error("answer without a request");
	a_write_rdata_zero: assert property (bus_req && bus_write |=> bus_rdata_q == 32'h0)
		else $error("read data not zero after a write");
	a_limit_bits_kept: assert property (s_rd ##0 bus_addr == CMAX_OFFSET |=>
		bus_rdata_q[31:16] == 16'h0 && (bus_rdata_q[15:0] & ~CMAX_MASK) == 16'h0)
		else $error("unimplemented limit bits read nonzero");
	a_word_one_top: assert property (s_rd ##0 bus_addr == 13'h1004 |=> bus_rdata_q[31:8] == 24'h0)
		else $error("bitmap bits above width read nonzero");
	a_upper_words_zero: assert property (s_rd ##0 bus_addr >= 13'h1008 |=> bus_rdata_q == 32'h0)
		else $error("bitmap word beyond width read nonzero");
	a_query_done: assert property (qry_valid |=> qry_done_q)
		else $error("query not finished one cycle later");
	a_portion_beyond: assert property (qry_valid && qry_portion >= 16'h0028 |=> !qry_allow_q)
		else $error("portion beyond width allowed");
	a_bad_partition: assert property (qry_valid && qry_partition > PARTITION_ID_MAX |=>
		qry_limit_q == 16'h0 && !qry_allow_q)
		else $error("out of range partition gave settings");
	a_query_holds: assert property (!qry_valid |=> $stable(qry_allow_q) && $stable(qry_limit_q))
		else $error("query result changed without a query");
endmodule
bind ccp_config_regs ccp_config_regs_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_ack_q(bus_ack_q),
	.bus_rdata_q(bus_rdata_q), .qry_valid(qry_valid), .qry_partition(qry_partition),
	.qry_portion(qry_portion), .qry_done_q(qry_done_q), .qry_allow_q(qry_allow_q),
	.qry_limit_q(qry_limit_q));

//--- verification/testbench.sv
// Self-checking bench for the cache partition configuration bank
`timescale 1ns/100ps
module testbench;
	import ccp_pkg::*;
	logic ref_clk = 0, rst_n = 0, req = 0, wr = 0, sec = 0, qv = 0, qs = 0, sf = 1;
	logic [12:0] ad = 0;
	logic [31:0] wd = 0, rdat;
	logic [15:0] sp = 0, qp = 0, qo = 0, lim;
	logic [3:0] si = 0, qi = 0;
	logic ack, done, allow;
	int miscompares = 0, comparisons = 0;
	// Both selector copies follow one setting; the pages still keep separate storage
	ccp_config_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req), .bus_write(wr),
		.bus_secure(sec), .bus_addr(ad), .bus_wdata(wd), .bus_ack_q(ack), .bus_rdata_q(rdat),
		.sel_s_partition(sp), .sel_s_instance(si), .sel_s_internal(sf),
		.sel_ns_partition(sp), .sel_ns_instance(si), .sel_ns_internal(sf),
		.qry_valid(qv), .qry_secure(qs), .qry_partition(qp), .qry_instance(qi),
		.qry_portion(qo), .qry_done_q(done), .qry_allow_q(allow), .qry_limit_q(lim));
	always #50 ref_clk = ~ref_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus access; read data of a write is expected to be zero
	task acc(input logic w, input logic s, input logic [12:0] a, input logic [31:0] d,
		input logic [31:0] exp);
		@(posedge ref_clk);
		req <= 1;
		wr <= w;
		sec <= s;
		ad <= a;
		wd <= d;
		@(posedge ref_clk);
		req <= 0;
		#1 chk(ack, 1);
		chk(rdat, exp);
	endtask
	task sel(input logic [15:0] p, input logic [3:0] i, input logic f);
		@(posedge ref_clk);
		sp <= p;
		si <= i;
		sf <= f;
	endtask
	task q(input logic s, input logic [15:0] p, input logic [3:0] i, input logic [15:0] o,
		input logic a, input logic [15:0] l);
		@(posedge ref_clk);
		qv <= 1;
		qs <= s;
		qp <= p;
		qi <= i;
		qo <= o;
		@(posedge ref_clk);
		qv <= 0;
		#1 chk(done, 1);
		chk(allow, a);
		chk(lim, l);
	endtask
	task close_out;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Reset, then accesses with an idle cycle between each, across both pages
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1;
		sel(16'h0001, 4'h0, 1);
		acc(0, 1, CMAX_OFFSET, 0, 32'h0000FFF0);
		acc(0, 1, BITMAP_BASE, 0, 32'hFFFFFFFF);
		acc(0, 1, 13'h1004, 0, 32'h000000FF);
		acc(0, 1, 13'h1008, 0, 32'h00000000);
		acc(1, 1, CMAX_OFFSET, 32'hFFFF1234, 0);
		acc(0, 1, CMAX_OFFSET, 0, 32'h00001230);
		acc(0, 0, CMAX_OFFSET, 0, 32'h0000FFF0);
		acc(1, 1, BITMAP_BASE, 32'h0000000F, 0);
		acc(1, 1, 13'h1004, 32'hFFFFFF7F, 0);
		acc(0, 1, 13'h1004, 0, 32'h0000007F);
		acc(1, 1, 13'h1001, 32'hFFFFFFFF, 0);
		acc(1, 1, 13'h0100, 32'hFFFFFFFF, 0);
		acc(0, 1, 13'h0100, 0, 32'h00000000);
		acc(0, 1, BITMAP_BASE, 0, 32'h0000000F);
		q(1, 16'h0001, 4'h0, 16'h0003, 1, 16'h1230);
		q(1, 16'h0001, 4'h0, 16'h0004, 0, 16'h1230);
		q(1, 16'h0001, 4'h0, 16'h0027, 0, 16'h1230);
		q(1, 16'h0001, 4'h0, 16'h0026, 1, 16'h1230);
		q(1, 16'h0001, 4'h0, 16'h0028, 0, 16'h1230);
		q(0, 16'h0001, 4'h0, 16'h0004, 1, 16'hFFF0);
		q(1, 16'h0001, 4'h1, 16'h0004, 1, 16'hFFF0);
		q(1, 16'h0004, 4'h0, 16'h0000, 0, 16'h0000);
		sel(16'h0001, 4'h1, 1);
		acc(0, 1, CMAX_OFFSET, 0, 32'h0000FFF0);
		sel(16'h0001, 4'h0, 0);
		acc(1, 1, CMAX_OFFSET, 32'h00000000, 0);
		acc(0, 1, CMAX_OFFSET, 0, 32'h00000000);
		sel(16'h0001, 4'h0, 1);
		acc(0, 1, CMAX_OFFSET, 0, 32'h00001230);
		sel(16'h0004, 4'h0, 1);
		acc(0, 1, CMAX_OFFSET, 0, 32'h00000000);
		close_out;
	end
endmodule
